// ---- rtl/usb_out_ep_pkg.sv ----
// Constants, types and layouts for the OUT endpoint configuration block
// Function
// R01 - Endpoint works only while enable bit set
// R02 - Bit six selects isochronous, else control/bulk
// R03 - Toggle inverts after good matching data stage
// R04 - Double buffer mode uses X and Y
// R05 - Single buffer mode uses only X
// R06 - Stall bit answers transactions with STALL
// R07 - Control setup always accepted, even stalled
// R08 - Control data and status stages get STALL
// R09 - Firmware clears stall on halt clear, reset
// R10 - Control write overrun sets stall by hardware
// R11 - Hardware stall raises endpoint zero interrupt
// R12 - Interrupt reaches controller only when enabled
// R13 - Bits one and zero reserved, no function
// R14 - Good OUT sets no-ack; later get NAK
// R15 - Buffer size in eight byte units, both
// R16 - Double buffering alternates, X first after enable
// R17 - Mismatched PID acknowledged, discarded, nothing changes; the code still sets the discard status flag
package usb_out_ep_pkg;

  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_XCNT = 8'h04;
  localparam logic [7:0] ADDR_YCNT = 8'h08;
  localparam logic [7:0] ADDR_BSIZE = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

  localparam int CFG_EN_BIT = 7;
  localparam int CFG_ISO_BIT = 6;
  localparam int CFG_TOG_BIT = 5;
  localparam int CFG_DUAL_BIT = 4;
  localparam int CFG_STALL_BIT = 3;
  localparam int CFG_IE_BIT = 2;
  localparam int NACK_BIT = 7;

  localparam int EVT_RX = 0;
  localparam int EVT_HWSTALL = 1;
  localparam int EVT_DISCARD = 2;
  localparam int NUM_EVT = 3;

  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] BSIZE_RST = 8'h00;
  localparam logic [NUM_EVT-1:0] MASK_RST = 3'h0;

  localparam logic [2:0] BSIZE_UNIT_PAD = 3'h0;

  typedef enum logic [1:0] {
    HS_NONE = 2'b00,
    HS_ACK = 2'b01,
    HS_NAK = 2'b10,
    HS_STALL = 2'b11
  } handshake_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RECV = 2'b01,
    ST_REJECT = 2'b10
  } ep_state_e;

  typedef struct packed {
    logic token;
    logic setup;
    logic status;
    logic done;
    logic crc_ok;
    logic pid_data1;
    logic overrun;
    logic [6:0] count;
  } sie_in_s;

  typedef struct packed {
    logic hs_valid;
    handshake_e hs;
    logic wr_en;
    logic buf_y;
  } sie_out_s;

endpackage

// ---- rtl/sticky_flag.sv ----
// Sticky event flag, set wins over write-one-to-clear
`timescale 1ns/10ps
module sticky_flag (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic set,
  input wire logic clr,
  output logic q
);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      q <= 1'b0;
    end else if (ce) begin
      if (set) begin
        q <= 1'b1;
      end else if (clr) begin
        q <= 1'b0;
      end
    end
  end

endmodule

// ---- rtl/usb_out_ep_cfg.sv ----
// OUT endpoint configuration, buffer manager decisions and register slave
`timescale 1ns/10ps
module usb_out_ep_cfg #(
  parameter bit IS_CONTROL = 1'b1
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire usb_out_ep_pkg::sie_in_s sie_i,
  output usb_out_ep_pkg::sie_out_s sie_o,
  output logic [10:0] buf_bytes,
  output logic irq
);
  import usb_out_ep_pkg::*;

  logic [7:0] cfg_r;
  logic [7:0] cfg_nxt;
  logic [7:0] xcnt_r;
  logic [7:0] xcnt_nxt;
  logic [7:0] ycnt_r;
  logic [7:0] ycnt_nxt;
  logic [7:0] bsize_r;
  logic [NUM_EVT-1:0] mask_r;
  logic [NUM_EVT-1:0] stat;
  logic [NUM_EVT-1:0] evt;
  logic [NUM_EVT-1:0] evt_clr;
  logic wait_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_mux;
  logic bus_wr;
  logic wr_cfg;
  logic wr_xcnt;
  logic wr_ycnt;
  ep_state_e state_r;
  logic tgt_y_r;
  logic next_y_r;
  logic is_setup_r;
  logic is_status_r;
  handshake_e rej_hs_r;
  sie_out_s sie_o_r;
  logic irq_r;
  logic [10:0] buf_bytes_r;
  logic tok_live;
  logic tgt_y_now;
  logic tgt_nack;
  logic ok;
  logic pid_match;
  logic overrun_stall;
  logic fill;
  logic discard;
  logic tog_flip;
  logic en_rise;

  assign readdata = rdata_r;
  assign waitrequest = wait_r;
  assign sie_o = sie_o_r;
  assign irq = irq_r;
  assign buf_bytes = buf_bytes_r;

  // Avalon slave: one wait cycle, then the request is taken
  assign bus_wr = write && !wait_r;
  assign wr_cfg = bus_wr && (address == ADDR_CFG);
  assign wr_xcnt = bus_wr && (address == ADDR_XCNT);
  assign wr_ycnt = bus_wr && (address == ADDR_YCNT);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wait_r <= 1'b1;
    end else if (ce) begin
      if (!wait_r) begin
        wait_r <= 1'b1;
      end else if (read || write) begin
        wait_r <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    case (address)
      ADDR_CFG: rd_mux[7:0] = cfg_r;
      ADDR_XCNT: rd_mux[7:0] = xcnt_r;
      ADDR_YCNT: rd_mux[7:0] = ycnt_r;
      ADDR_BSIZE: rd_mux[7:0] = bsize_r;
      ADDR_IRQ_STAT: rd_mux[NUM_EVT-1:0] = stat;
      ADDR_IRQ_MASK: rd_mux[NUM_EVT-1:0] = mask_r;
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 32'h0;
    end else if (ce && read && wait_r) begin
      rdata_r <= rd_mux;
    end
  end

  // Token decision inputs
  assign tok_live = sie_i.token && (state_r == ST_IDLE);
  assign tgt_y_now = cfg_r[CFG_DUAL_BIT] && next_y_r;
  assign tgt_nack = tgt_y_now ? ycnt_r[NACK_BIT] : xcnt_r[NACK_BIT];

  // End of packet evaluation
  assign ok = (state_r == ST_RECV) && sie_i.done && sie_i.crc_ok;
  assign pid_match = (sie_i.pid_data1 == cfg_r[CFG_TOG_BIT]);
  // R10 overrun stall
  assign overrun_stall = ok && IS_CONTROL && !is_setup_r && !is_status_r &&
                         sie_i.overrun;
  assign fill = ok && !overrun_stall && !is_status_r &&
                (is_setup_r || pid_match);
  // R17 mismatch discarded
  assign discard = ok && !overrun_stall && !is_status_r && !is_setup_r &&
                   !pid_match;
  // R03 toggle on data stage
  assign tog_flip = fill && !is_setup_r;

  // Configuration byte, hardware updates win over firmware writes
  always_comb begin
    cfg_nxt = cfg_r;
    // R13 reserved bits stored only
    if (wr_cfg) begin
      cfg_nxt = writedata[7:0];
    end
    // R10 hardware stall set
    if (overrun_stall) begin
      cfg_nxt[CFG_STALL_BIT] = 1'b1;
    end
    if (tog_flip) begin
      cfg_nxt[CFG_TOG_BIT] = ~cfg_r[CFG_TOG_BIT];
    end else if (fill && is_setup_r) begin
      cfg_nxt[CFG_TOG_BIT] = 1'b1;
    end
  end

  assign en_rise = cfg_nxt[CFG_EN_BIT] && !cfg_r[CFG_EN_BIT];

  // R14 no-ack and count update
  always_comb begin
    xcnt_nxt = xcnt_r;
    ycnt_nxt = ycnt_r;
    if (wr_xcnt) begin
      xcnt_nxt = writedata[7:0];
    end
    if (wr_ycnt) begin
      ycnt_nxt = writedata[7:0];
    end
    if (fill && tgt_y_r) begin
      ycnt_nxt = {1'b1, sie_i.count};
    end else if (fill) begin
      xcnt_nxt = {1'b1, sie_i.count};
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r <= CFG_RST;
      xcnt_r <= CNT_RST;
      ycnt_r <= CNT_RST;
    end else if (ce) begin
      cfg_r <= cfg_nxt;
      xcnt_r <= xcnt_nxt;
      ycnt_r <= ycnt_nxt;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bsize_r <= BSIZE_RST;
      mask_r <= MASK_RST;
    end else if (ce && bus_wr) begin
      if (address == ADDR_BSIZE) begin
        bsize_r <= writedata[7:0];
      end
      if (address == ADDR_IRQ_MASK) begin
        mask_r <= writedata[NUM_EVT-1:0];
      end
    end
  end

  // R16 alternate buffers, X first
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      next_y_r <= 1'b0;
    end else if (ce) begin
      if (en_rise) begin
        next_y_r <= 1'b0;
      end else if (fill && !is_setup_r) begin
        next_y_r <= cfg_r[CFG_DUAL_BIT] && !tgt_y_r;
      end
    end
  end

  // Transaction sequencer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      tgt_y_r <= 1'b0;
      is_setup_r <= 1'b0;
      is_status_r <= 1'b0;
      rej_hs_r <= HS_NONE;
    end else if (ce) begin
      case (state_r)
        ST_IDLE: begin
          // R01 R02 only enabled non-isochronous endpoint
          if (tok_live && cfg_r[CFG_EN_BIT] && !cfg_r[CFG_ISO_BIT]) begin
            is_setup_r <= sie_i.setup;
            is_status_r <= sie_i.status;
            // R07 setup always taken into X
            if (sie_i.setup && IS_CONTROL) begin
              state_r <= ST_RECV;
              tgt_y_r <= 1'b0;
            // R06 R08 stalled endpoint
            end else if (cfg_r[CFG_STALL_BIT]) begin
              state_r <= ST_REJECT;
              rej_hs_r <= HS_STALL;
            end else if (sie_i.status) begin
              state_r <= ST_RECV;
              tgt_y_r <= 1'b0;
            // R14 busy buffer answers NAK
            end else if (tgt_nack) begin
              state_r <= ST_REJECT;
              rej_hs_r <= HS_NAK;
            end else begin
              // R04 R05 buffer choice
              state_r <= ST_RECV;
              tgt_y_r <= tgt_y_now;
            end
          end
        end
        ST_RECV: begin
          if (sie_i.done) begin
            state_r <= ST_IDLE;
          end
        end
        ST_REJECT: begin
          if (sie_i.done) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Handshake and buffer write enables toward the serial engine
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sie_o_r <= '{hs_valid: 1'b0, hs: HS_NONE, wr_en: 1'b0, buf_y: 1'b0};
    end else if (ce) begin
      sie_o_r.hs_valid <= 1'b0;
      sie_o_r.hs <= HS_NONE;
      if (state_r == ST_REJECT && sie_i.done) begin
        sie_o_r.hs_valid <= 1'b1;
        sie_o_r.hs <= rej_hs_r;
      end else if (state_r == ST_RECV && sie_i.done && sie_i.crc_ok) begin
        sie_o_r.hs_valid <= 1'b1;
        sie_o_r.hs <= overrun_stall ? HS_STALL : HS_ACK;
      end
      sie_o_r.wr_en <= (state_r == ST_RECV) && !sie_i.done && !is_status_r;
      sie_o_r.buf_y <= tgt_y_r;
    end
  end

  // R15 size in eight byte units
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      buf_bytes_r <= 11'h0;
    end else if (ce) begin
      buf_bytes_r <= {bsize_r, BSIZE_UNIT_PAD};
    end
  end

  // R11 hardware stall is an event
  assign evt[EVT_RX] = fill;
  assign evt[EVT_HWSTALL] = overrun_stall;
  assign evt[EVT_DISCARD] = discard;
  assign evt_clr = (bus_wr && address == ADDR_IRQ_STAT) ?
                   writedata[NUM_EVT-1:0] : {NUM_EVT{1'b0}};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVT; gi++) begin : g_evt
      sticky_flag u_flag (
        .mclk(mclk),
        .reset_n(reset_n),
        .ce(ce),
        .set(evt[gi]),
        .clr(evt_clr[gi]),
        .q(stat[gi])
      );
    end
  endgenerate

  // R12 interrupt gated by enable bit
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_r <= 1'b0;
    end else if (ce) begin
      irq_r <= cfg_r[CFG_IE_BIT] && (|(stat & mask_r));
    end
  end

  disabled_ignore_a: assert property ( // R01
    @(posedge mclk) disable iff (!reset_n)
    ce && tok_live && !cfg_r[CFG_EN_BIT] |=> state_r == ST_IDLE)
    else $error("disabled endpoint took a token");

  iso_ignore_a: assert property ( // R02
    @(posedge mclk) disable iff (!reset_n)
    ce && tok_live && cfg_r[CFG_ISO_BIT] |=> state_r == ST_IDLE)
    else $error("isochronous endpoint took a token");

  toggle_flip_a: assert property ( // R03
    @(posedge mclk) disable iff (!reset_n)
    ce && tog_flip && !wr_cfg |=>
    cfg_r[CFG_TOG_BIT] != $past(cfg_r[CFG_TOG_BIT]))
    else $error("toggle did not invert");

  dual_alt_a: assert property ( // R04
    @(posedge mclk) disable iff (!reset_n)
    ce && fill && !is_setup_r && cfg_r[CFG_DUAL_BIT] && !en_rise |=>
    next_y_r != $past(tgt_y_r))
    else $error("double buffering did not alternate");

  single_x_a: assert property ( // R05
    @(posedge mclk) disable iff (!reset_n)
    ce && tok_live && !cfg_r[CFG_DUAL_BIT] |=>
    state_r != ST_RECV || !tgt_y_r)
    else $error("single buffer mode chose Y");

  stall_hs_a: assert property ( // R06
    @(posedge mclk) disable iff (!reset_n)
    ce && tok_live && cfg_r[CFG_EN_BIT] && !cfg_r[CFG_ISO_BIT] &&
    !sie_i.setup && cfg_r[CFG_STALL_BIT] |=>
    state_r == ST_REJECT && rej_hs_r == HS_STALL)
    else $error("stalled endpoint did not answer STALL");

  setup_take_a: assert property ( // R07
    @(posedge mclk) disable iff (!reset_n)
    ce && tok_live && cfg_r[CFG_EN_BIT] && !cfg_r[CFG_ISO_BIT] &&
    sie_i.setup && IS_CONTROL |=> state_r == ST_RECV && !tgt_y_r)
    else $error("setup not accepted");

  overrun_stall_a: assert property ( // R10
    @(posedge mclk) disable iff (!reset_n)
    ce && overrun_stall |=> cfg_r[CFG_STALL_BIT] && stat[EVT_HWSTALL] &&
    sie_o_r.hs == HS_STALL)
    else $error("overrun did not stall and flag");

  irq_gate_a: assert property ( // R12
    @(posedge mclk) disable iff (!reset_n)
    ce && !cfg_r[CFG_IE_BIT] |=> !irq_r)
    else $error("interrupt raised while disabled");

  nak_busy_a: assert property ( // R14
    @(posedge mclk) disable iff (!reset_n)
    ce && tok_live && cfg_r[CFG_EN_BIT] && !cfg_r[CFG_ISO_BIT] &&
    !sie_i.setup && !sie_i.status && !cfg_r[CFG_STALL_BIT] && tgt_nack |=>
    state_r == ST_REJECT && rej_hs_r == HS_NAK)
    else $error("busy buffer not answered NAK");

  size_units_a: assert property ( // R15
    @(posedge mclk) disable iff (!reset_n)
    ce |=> buf_bytes_r == {$past(bsize_r), 3'h0})
    else $error("buffer size not in eight byte units");

  discard_keep_a: assert property ( // R17
    @(posedge mclk) disable iff (!reset_n)
    ce && discard && !bus_wr |=>
    cfg_r[CFG_TOG_BIT] == $past(cfg_r[CFG_TOG_BIT]) &&
    xcnt_r == $past(xcnt_r) && ycnt_r == $past(ycnt_r) &&
    sie_o_r.hs == HS_ACK)
    else $error("discarded packet changed state");

endmodule

// ---- sim/sie_host_model.sv ----
// Host and serial engine model driving OUT transactions into the endpoint
`timescale 1ns/10ps
module sie_host_model import usb_out_ep_pkg::*; (
  input wire logic mclk,
  output usb_out_ep_pkg::sie_in_s sie_i,
  input wire usb_out_ep_pkg::sie_out_s sie_o
);
  initial begin
    sie_i = '0;
  end

  // One transaction: token, packet end, then wait for the handshake
  task automatic xfer(input logic su, input logic st, input logic p1,
                      input logic crc, input logic ovr,
                      input logic [6:0] cnt, output logic [1:0] hs,
                      output logic got, output logic [1:0] y);
    int i;
    begin
      got = 1'b0;
      hs = 2'b00;
      @(posedge mclk);
      sie_i.token <= 1'b1;
      sie_i.setup <= su;
      sie_i.status <= st;
      @(posedge mclk);
      sie_i.token <= 1'b0;
      sie_i.setup <= ~su;
      sie_i.status <= ~st;
      @(posedge mclk);
      #1 y = {sie_o.wr_en, sie_o.buf_y};
      @(posedge mclk);
      sie_i.done <= 1'b1;
      sie_i.crc_ok <= crc;
      sie_i.pid_data1 <= p1;
      sie_i.overrun <= ovr;
      sie_i.count <= cnt;
      @(posedge mclk);
      // Qualifiers no longer valid once the packet end has passed
      sie_i.done <= 1'b0;
      sie_i.crc_ok <= ~crc;
      sie_i.pid_data1 <= ~p1;
      sie_i.overrun <= ~ovr;
      sie_i.count <= ~cnt;
      for (i = 0; i < 4; i++) begin
        #1;
        if (sie_o.hs_valid === 1'b1 && !got) begin
          got = 1'b1;
          hs = sie_o.hs;
        end
        @(posedge mclk);
      end
    end
  endtask
endmodule

// ---- sim/tb_usb_out_ep_cfg.sv ----
// Self-checking bench for the OUT endpoint configuration block
`timescale 1ns/10ps
module tb_usb_out_ep_cfg;
  import usb_out_ep_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  sie_in_s sie_i;
  sie_out_s sie_o;
  logic [10:0] buf_bytes;
  logic irq;
  int num_errors = 0;
  int n_checks = 0;

  usb_out_ep_cfg #(.IS_CONTROL(1'b1)) DUT (.mclk(mclk), .reset_n(reset_n),
    .ce(ce), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .sie_i(sie_i), .sie_o(sie_o), .buf_bytes(buf_bytes), .irq(irq));
  sie_host_model host (.mclk(mclk), .sie_i(sie_i), .sie_o(sie_o));

  initial begin
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Avalon cycle held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    do begin
      @(posedge mclk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, exp);
  endtask

  task automatic tx(input string nm, input logic [4:0] k,
                    input logic [6:0] cnt, input logic eg,
                    input logic [1:0] ehs, output logic [1:0] y);
    logic [1:0] hs;
    logic got;
    host.xfer(k[4], k[3], k[2], k[1], k[0], cnt, hs, got, y);
    chk({nm, " got"}, got, eg);
    chk({nm, " hs"}, hs, ehs);
  endtask

  task automatic t_reset();
    logic [1:0] y;
    for (int a = 0; a < 6; a++) rd("reset", 8'(a * 4), 32'h0);
    wr(8'h18, 32'hff);
    rd("unmapped", 8'h18, 32'h0);
    wr(ADDR_CFG, 32'h03);
    rd("cfg rsvd", ADDR_CFG, 32'h03);
    tx("disabled", 5'b00010, 7'h05, 1'b0, 2'b00, y);
  endtask

  task automatic t_rx();
    logic [1:0] y;
    wr(ADDR_IRQ_MASK, 32'h7);
    wr(ADDR_BSIZE, 32'h18);
    // Clock enable low freezes the size output
    ce <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("bytes frozen", buf_bytes, 32'h0);
    ce <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("bytes", buf_bytes, 32'h0c0);
    wr(ADDR_CFG, 32'h84);
    tx("rx1", 5'b00010, 7'h05, 1'b1, HS_ACK, y);
    chk("rx1 x", y, 32'h2);
    rd("xcnt", ADDR_XCNT, 32'h85);
    rd("toggle", ADDR_CFG, 32'ha4);
    rd("stat rx", ADDR_IRQ_STAT, 32'h1);
    chk("irq on", irq, 32'h1);
    tx("nak", 5'b00110, 7'h05, 1'b1, HS_NAK, y);
    wr(ADDR_XCNT, 32'h0);
    tx("bad pid", 5'b00010, 7'h07, 1'b1, HS_ACK, y);
    rd("tog kept", ADDR_CFG, 32'ha4);
    rd("x kept", ADDR_XCNT, 32'h0);
    rd("stat disc", ADDR_IRQ_STAT, 32'h5);
    wr(ADDR_CFG, 32'ha0);
    rd("cfg ie off", ADDR_CFG, 32'ha0);
    chk("irq gated", irq, 32'h0);
    wr(ADDR_IRQ_STAT, 32'h7);
    rd("stat w1c", ADDR_IRQ_STAT, 32'h0);
    tx("crc bad", 5'b00000, 7'h05, 1'b0, 2'b00, y);
  endtask

  task automatic t_iso();
    logic [1:0] y;
    wr(ADDR_CFG, 32'hc0);
    tx("iso", 5'b00010, 7'h05, 1'b0, 2'b00, y);
  endtask

  task automatic t_dual();
    logic [1:0] y;
    wr(ADDR_CFG, 32'h0);
    wr(ADDR_CFG, 32'h90);
    tx("db1", 5'b00010, 7'h01, 1'b1, HS_ACK, y);
    chk("db1 x", y, 32'h2);
    tx("db2", 5'b00110, 7'h03, 1'b1, HS_ACK, y);
    chk("db2 y", y, 32'h3);
    rd("ycnt", ADDR_YCNT, 32'h83);
    wr(ADDR_XCNT, 32'h0);
    tx("db3", 5'b00010, 7'h02, 1'b1, HS_ACK, y);
    chk("db3 x", y, 32'h2);
  endtask

  task automatic t_stall();
    logic [1:0] y;
    wr(ADDR_CFG, 32'h0);
    wr(ADDR_CFG, 32'h8c);
    wr(ADDR_XCNT, 32'h0);
    wr(ADDR_IRQ_STAT, 32'h7);
    tx("stall data", 5'b00010, 7'h01, 1'b1, HS_STALL, y);
    chk("stall y", y, 32'h0);
    tx("stall stat", 5'b01010, 7'h00, 1'b1, HS_STALL, y);
    tx("setup", 5'b10010, 7'h08, 1'b1, HS_ACK, y);
    chk("setup x", y, 32'h2);
    rd("setup tog", ADDR_CFG, 32'hac);
    wr(ADDR_CFG, 32'ha4);
    wr(ADDR_XCNT, 32'h0);
    tx("overrun", 5'b00111, 7'h40, 1'b1, HS_STALL, y);
    rd("hw stall", ADDR_CFG, 32'hac);
    rd("stat hw", ADDR_IRQ_STAT, 32'h3);
    chk("irq hw", irq, 32'h1);
    wr(ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge mclk);
    chk("irq masked", irq, 32'h0);
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #300000;
    num_errors++;
    close_out();
  end

  initial begin
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset();
    t_rx();
    t_iso();
    t_dual();
    t_stall();
    close_out();
  end
endmodule
